//--- core/sia_defines.svh
// constants for the shared indirect access, self-test and strap status bank
// assumes a 32-bit classic wishbone slave with one register per aligned word
`ifndef SIA_DEFINES_SVH
`define SIA_DEFINES_SVH

// register indices; byte address is four times the index
`define SIA_IDX_CTRL 8'hb0
`define SIA_IDX_OFFSET 8'hb1
`define SIA_IDX_WINDOW 8'hb2
`define SIA_IDX_SELFTEST 8'hb3
`define SIA_IDX_RSV_B4 8'hb4
`define SIA_IDX_RSV_B5 8'hb5
`define SIA_IDX_RSV_B6 8'hb6
`define SIA_IDX_RSV_B7 8'hb7
`define SIA_IDX_STRAP 8'hb8

// reset values
`define SIA_RST_TARGET 4'h7
`define SIA_RST_OFFSET 8'h3a
`define SIA_RST_SELFTEST 8'h08
`define SIA_RST_RSV_B4 8'h25
`define SIA_RST_RSV_B5 8'h00
`define SIA_RST_RSV_B6 8'h18
`define SIA_RST_RSV_B7 8'h00

// control field positions
`define SIA_CTRL_SEL_HI 5
`define SIA_CTRL_SEL_LO 2
`define SIA_CTRL_STEP 1
`define SIA_CTRL_PREF 0

// self-test field positions
`define SIA_ST_MODE_HI 7
`define SIA_ST_MODE_LO 6
`define SIA_ST_CFG 3
`define SIA_ST_CLK_HI 2
`define SIA_ST_CLK_LO 1
`define SIA_ST_EN 0

// remote serializer offset that receives the clock source
`define SIA_REMOTE_CLKSRC_OFS 8'h14

// target selector codes
`define SIA_TGT_PATGEN 4'h0
`define SIA_TGT_RX0 4'h1
`define SIA_TGT_RX1 4'h2
`define SIA_TGT_RX2 4'h3
`define SIA_TGT_RX3 4'h4
`define SIA_TGT_RXSH 4'h5
`define SIA_TGT_RXALL 4'h6
`define SIA_TGT_OUTRSV 4'h7

`endif

//--- core/sia_pkg.sv
// types for the shared indirect access, self-test and strap status bank
// assumes sia_defines.svh supplies the numeric constants
package sia_pkg;

	// one enable per internal block: [0] pattern gen, [4:1] rx 0-3, [5] rx shared, [6] output
	typedef logic [6:0] sia_target_vec_t;

	typedef struct packed {
		logic wr;
		logic rd;
		sia_target_vec_t target;
		logic [7:0] offset;
		logic [7:0] wdata;
	} sia_ind_req_t;

	typedef struct packed {
		logic wr;
		logic [7:0] offset;
		logic [1:0] clk_source;
	} sia_remote_wr_t;

	typedef enum logic [1:0] {
		SIA_OUT_NONE,
		SIA_OUT_ALTERNATE,
		SIA_OUT_DATA
	} sia_out_mode_t;

endpackage : sia_pkg

//--- core/sia_regs.sv
// shared indirect access port, self-test control and strap status registers
// assumes a classic wishbone master and internal blocks that answer reads
// combinationally from the offset and target they are given
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
`include "sia_defines.svh"

module sia_regs #(
	parameter int ADDR_W = 12,
	parameter logic [1:0] CLKSRC_DEFAULT = 2'h0
) (
	input wire logic clk_i, // 40 MHz clock
	input wire logic rst_i, // synchronous reset, active high
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write enable
	input wire logic [ADDR_W-1:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	output sia_pkg::sia_ind_req_t ind_req_o, // indirect request to blocks
	input wire logic [7:0] ind_rdata_i, // byte from selected block
	output logic self_test_en_o, // self-test enabled
	output sia_pkg::sia_out_mode_t self_test_out_mode_o, // output toggling
	output logic [1:0] self_test_clk_source_o, // effective clock source
	output sia_pkg::sia_remote_wr_t remote_wr_o, // write to remote serializer
	input wire logic [2:0] strap_index_i, // index strap decode
	input wire logic [2:0] strap_mode_i // mode strap decode
);
	import sia_pkg::*;

	function automatic sia_target_vec_t target_decode(input logic [3:0] code,
		input logic is_write);
		sia_target_vec_t v;
		v = '0;
		unique case (code)
			`SIA_TGT_PATGEN: v[0] = 1'b1;
			`SIA_TGT_RX0: v[1] = 1'b1;
			`SIA_TGT_RX1: v[2] = 1'b1;
			`SIA_TGT_RX2: v[3] = 1'b1;
			`SIA_TGT_RX3: v[4] = 1'b1;
			`SIA_TGT_RXSH: v[5] = 1'b1;
			// broadcast only for writes; reads have no single source
			`SIA_TGT_RXALL: v[4:1] = is_write ? 4'hf : 4'h0;
			`SIA_TGT_OUTRSV: v[6] = 1'b1;
			default: v = '0;
		endcase
		return v;
	endfunction : target_decode

	function automatic sia_out_mode_t mode_decode(input logic [1:0] bits);
		sia_out_mode_t m;
		m = SIA_OUT_NONE;
		if (bits[1]) begin
			m = SIA_OUT_DATA;
		end else if (bits[0]) begin
			m = SIA_OUT_ALTERNATE;
		end
		return m;
	endfunction : mode_decode

	logic [3:0] target_r;
	logic step_r;
	logic pref_r;
	logic [7:0] offset_r;
	logic [7:0] offset_nxt;
	logic [7:0] window_r;
	logic [7:0] selftest_r;
	logic [7:0] selftest_nxt;
	logic index_decode_complete_r;
	logic mode_done_r;
	logic [2:0] idx_r;
	logic [2:0] mode_r;
	logic st_en_d_r;

	// bus decode
	wire logic req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire logic lane0 = wb_sel_i[0];
	wire logic aligned = (wb_adr_i[1:0] == 2'b00);
	wire logic [7:0] reg_idx = wb_adr_i[9:2];
	wire logic upper_zero = (wb_adr_i[ADDR_W-1:10] == '0);
	wire logic hit = req & aligned & upper_zero;
	wire logic hit_ctrl = hit & (reg_idx == `SIA_IDX_CTRL);
	wire logic hit_ofs = hit & (reg_idx == `SIA_IDX_OFFSET);
	wire logic hit_win = hit & (reg_idx == `SIA_IDX_WINDOW);
	wire logic hit_st = hit & (reg_idx == `SIA_IDX_SELFTEST);
	wire logic wr_ctrl = hit_ctrl & wb_we_i & lane0;
	wire logic wr_ofs = hit_ofs & wb_we_i & lane0;
	wire logic wr_win = hit_win & wb_we_i & lane0;
	wire logic rd_win = hit_win & ~wb_we_i;
	wire logic wr_st = hit_st & wb_we_i & lane0;

	wire logic [7:0] ctrl_view = {2'b00, target_r, step_r, pref_r};
	wire logic [7:0] strap_view = {index_decode_complete_r, idx_r, mode_done_r, mode_r};

	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		if (hit) begin
			unique case (reg_idx)
				`SIA_IDX_CTRL: rd_byte = ctrl_view;
				`SIA_IDX_OFFSET: rd_byte = offset_r;
				`SIA_IDX_WINDOW: rd_byte = ind_rdata_i;
				`SIA_IDX_SELFTEST: rd_byte = selftest_r;
				`SIA_IDX_RSV_B4: rd_byte = `SIA_RST_RSV_B4;
				`SIA_IDX_RSV_B5: rd_byte = `SIA_RST_RSV_B5;
				`SIA_IDX_RSV_B6: rd_byte = `SIA_RST_RSV_B6;
				`SIA_IDX_RSV_B7: rd_byte = `SIA_RST_RSV_B7;
				`SIA_IDX_STRAP: rd_byte = strap_view;
				default: rd_byte = 8'h00;
			endcase
		end
	end

	// offset: software write beats autostep; sum cut to 8 bits wraps at 0xff
	wire logic step_now = step_r & (wr_win | rd_win);
	assign offset_nxt = wr_ofs ? wb_dat_i[7:0] :
		step_now ? 8'(offset_r + 8'h01) : offset_r;
	// prefetch after offset write, and after a window read in autostep mode
	wire logic fetch_now = pref_r & (wr_ofs | (step_r & rd_win));

	// bit 3 set keeps the block's own configuration instead of bits 2:1
	wire logic [1:0] clk_src_eff = selftest_nxt[`SIA_ST_CFG] ? CLKSRC_DEFAULT :
		selftest_nxt[`SIA_ST_CLK_HI:`SIA_ST_CLK_LO];
	assign selftest_nxt = wr_st ? wb_dat_i[7:0] : selftest_r;
	wire logic st_en_nxt = selftest_nxt[`SIA_ST_EN];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= {24'h00_0000, rd_byte};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			target_r <= `SIA_RST_TARGET;
			step_r <= 1'b0;
			pref_r <= 1'b0;
		end else if (wr_ctrl) begin
			target_r <= wb_dat_i[`SIA_CTRL_SEL_HI:`SIA_CTRL_SEL_LO];
			step_r <= wb_dat_i[`SIA_CTRL_STEP];
			pref_r <= wb_dat_i[`SIA_CTRL_PREF];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			offset_r <= `SIA_RST_OFFSET;
			window_r <= 8'h00;
		end else begin
			offset_r <= offset_nxt;
			if (wr_win) begin
				window_r <= wb_dat_i[7:0];
			end
		end
	end

	// strobes leave with the offset they belong to: write uses the old offset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ind_req_o <= '0;
		end else begin
			ind_req_o.wr <= wr_win;
			ind_req_o.rd <= fetch_now;
			ind_req_o.wdata <= wr_win ? wb_dat_i[7:0] : window_r;
			ind_req_o.offset <= wr_win ? offset_r : offset_nxt;
			ind_req_o.target <= target_decode(wr_ctrl ?
				wb_dat_i[`SIA_CTRL_SEL_HI:`SIA_CTRL_SEL_LO] : target_r, wr_win);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			selftest_r <= `SIA_RST_SELFTEST;
			st_en_d_r <= 1'b0;
			self_test_en_o <= 1'b0;
			self_test_out_mode_o <= SIA_OUT_NONE;
			self_test_clk_source_o <= CLKSRC_DEFAULT;
			remote_wr_o <= '0;
		end else begin
			selftest_r <= selftest_nxt;
			st_en_d_r <= st_en_nxt;
			self_test_en_o <= st_en_nxt;
			self_test_out_mode_o <= mode_decode(
				selftest_nxt[`SIA_ST_MODE_HI:`SIA_ST_MODE_LO]);
			self_test_clk_source_o <= clk_src_eff;
			// one remote write on each enable rise
			remote_wr_o.wr <= st_en_nxt & ~st_en_d_r;
			remote_wr_o.offset <= `SIA_REMOTE_CLKSRC_OFS;
			remote_wr_o.clk_source <= clk_src_eff;
		end
	end

	// straps are taken one clock after reset release, never in reset itself
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			index_decode_complete_r <= 1'b0;
			mode_done_r <= 1'b0;
			idx_r <= 3'h0;
			mode_r <= 3'h0;
		end else if (!index_decode_complete_r) begin
			idx_r <= strap_index_i;
			mode_r <= strap_mode_i;
			index_decode_complete_r <= 1'b1;
			mode_done_r <= 1'b1;
		end
	end

endmodule : sia_regs

//--- sim/sia_regs_sva.sv
// bus and indirect port checks for sia_regs
// assumes one clock with synchronous active-high reset
`timescale 1ns/1ps
module sia_regs_sva #(
	parameter int ADDR_W = 12
) (
	input wire logic clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic wb_cyc_i, // cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write
	input wire logic [ADDR_W-1:0] wb_adr_i, // address
	input wire logic [3:0] wb_sel_i, // lanes
	input wire logic [31:0] wb_dat_i, // write data
	input wire logic [31:0] wb_dat_o, // read data
	input wire logic wb_ack_o, // ack
	input wire sia_pkg::sia_ind_req_t ind_req_o, // indirect request
	input wire logic self_test_en_o, // self-test on
	input wire sia_pkg::sia_remote_wr_t remote_wr_o // remote write
);
	import sia_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire win_wr = take && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_W'(12'h2c8);
	a_ack_next: assert property (take |=> wb_ack_o) else $error("no ack");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
	a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
	a_dat_high_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read bits set");
	a_window_write: assert property (win_wr |=> ind_req_o.wr &&
		{24'h0, ind_req_o.wdata} == ($past(wb_dat_i) & 32'h0000_00ff)) else $error("bad write");
	a_strobe_acked: assert property (ind_req_o.wr || ind_req_o.rd |-> wb_ack_o)
		else $error("strobe outside access");
	a_enable_by_write: assert property ($changed(self_test_en_o) |->
		wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2)) else $error("enable moved alone");
	a_remote_pulse: assert property (remote_wr_o.wr |->
		remote_wr_o.offset == 8'h14 ##1 !remote_wr_o.wr) else $error("bad remote write");
endmodule : sia_regs_sva

bind sia_regs sia_regs_sva #(.ADDR_W(ADDR_W)) sia_regs_sva_i (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.ind_req_o(ind_req_o), .self_test_en_o(self_test_en_o), .remote_wr_o(remote_wr_o));

//--- sim/sia_regs_bench.sv
// self-checking bench for sia_regs over classic wishbone
// assumes the acknowledge arrives within a few cycles
`timescale 1ns/1ps
module sia_regs_bench;
	import sia_pkg::*;
	logic clk_i, rst_i, cyc, stb, we, ack, st_en;
	logic [11:0] adr;
	logic [3:0] sel;
	logic [31:0] dat, rdat;
	logic [7:0] rd_byte, q;
	logic [2:0] s_idx, s_mode;
	logic [1:0] clk_src;
	sia_ind_req_t req, snap;
	sia_remote_wr_t rsnap;
	sia_out_mode_t mode;
	sia_remote_wr_t rwr;
	int fails, checked;
	sia_regs sia_regs_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .ind_req_o(req), .ind_rdata_i(rd_byte), .self_test_en_o(st_en),
		.self_test_out_mode_o(mode), .self_test_clk_source_o(clk_src), .remote_wr_o(rwr),
		.strap_index_i(s_idx), .strap_mode_i(s_mode));
	task automatic wrap_up;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	// answer taken at the falling edge of the ack cycle, released on the next rise
	task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc, stb, we} <= {2'h3, w};
		adr <= {2'h0, i, 2'h0};
		dat <= {24'h0, d};
		do begin
			@(negedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat[7:0];
		snap = req;
		rsnap = rwr;
		@(posedge clk_i);
		{cyc, stb} <= 2'h0;
		if (n >= 20) begin
			chk(8'h00, 8'h01);
			wrap_up();
		end
	endtask : wb
	task automatic check_resets;
		logic [7:0] rv [9];
		rv = '{8'h1c, 8'h3a, 8'h6c, 8'h08, 8'h25, 8'h00, 8'h18, 8'h00, 8'hda};
		for (int k = 0; k < 9; k++) begin
			wb(0, 8'hb0 + k[7:0], 0);
			chk(q, rv[k]);
		end
		wb(1, 8'hb4, 8'hff);
		wb(0, 8'hb4, 0);
		chk(q, 8'h25);
		wb(0, 8'hc0, 0);
		chk(q, 8'h00);
		sel <= 4'h0;
		wb(1, 8'hb1, 8'h77);
		sel <= 4'h1;
		wb(0, 8'hb1, 0);
		chk(q, 8'h3a);
	endtask : check_resets
	task automatic check_targets;
		logic [6:0] tv [8];
		tv = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h1e, 7'h40};
		for (int c = 0; c < 9; c++) begin
			wb(1, 8'hb0, c < 8 ? {2'h0, c[3:0], 2'h0} : 8'h3c);
			wb(1, 8'hb2, 8'h5a);
			chk({1'b0, snap.target}, c < 8 ? {1'b0, tv[c]} : 8'h00);
		end
	endtask : check_targets
	task automatic check_window;
		wb(1, 8'hb0, 8'h06);
		wb(1, 8'hb1, 8'hff);
		chk({7'h0, snap.rd}, 8'h00);
		wb(1, 8'hb2, 8'ha5);
		chk({snap.wr, snap.rd, 6'h0}, 8'h80);
		chk(snap.offset, 8'hff);
		chk(snap.wdata, 8'ha5);
		wb(1, 8'hb2, 8'h5a);
		chk(snap.offset, 8'h00);
		wb(0, 8'hb1, 0);
		chk(q, 8'h01);
		wb(1, 8'hb0, 8'h07);
		wb(1, 8'hb1, 8'h10);
		chk({snap.rd, snap.offset[6:0]}, 8'h90);
		wb(0, 8'hb2, 0);
		chk(q, 8'h6c);
		chk({snap.rd, snap.offset[6:0]}, 8'h91);
		wb(1, 8'hb0, 8'h05);
		wb(0, 8'hb2, 0);
		chk({7'h0, snap.rd}, 8'h00);
	endtask : check_window
	// check the enable level one falling edge after the write
	task automatic self_test(input logic [7:0] v, input logic en, input logic [7:0] e);
		wb(1, 8'hb3, v);
		if (en) chk({rsnap.wr, rsnap.offset[6:0]}, 8'h94);
		else chk({7'h0, rsnap.wr}, 8'h00);
		if (en) chk({6'h0, rsnap.clk_source}, {6'h0, e[3:2]});
		@(negedge clk_i);
		chk({st_en, 3'h0, clk_src, mode}, e);
	endtask : self_test
	initial begin
		clk_i = 0;
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin
		{rst_i, cyc, stb, we, adr, dat, sel} = {4'h8, 12'h0, 32'h0, 4'h1};
		{rd_byte, s_idx, s_mode} = {8'h6c, 3'h5, 3'h2};
		repeat (6) @(posedge clk_i);
		rst_i <= 0;
		check_resets();
		check_targets();
		check_window();
		self_test(8'h47, 1, 8'h8d);
		self_test(8'hc6, 0, 8'h0e);
		self_test(8'h0f, 1, 8'h80);
		wrap_up();
	end
endmodule : sia_regs_bench
